// [hw/table_readback_params.svh]
// Offsets, field positions, reset values and counts for the table read-back block
`ifndef TABLE_READBACK_PARAMS_SVH
`define TABLE_READBACK_PARAMS_SVH

// -----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define IDX_TABLE_CMD 14'h1804
`define IDX_READ_LOW 14'h1805
`define IDX_READ_HIGH 14'h1806
`define IDX_INGRESS_CFG 14'h1807

// -----------------------------------------------------------------
// Command register fields
// -----------------------------------------------------------------
`define CMD_GET_FIRST_BIT 0
`define CMD_GET_NEXT_BIT 1
`define CMD_BUSY_BIT 31

// -----------------------------------------------------------------
// Ingress configuration fields
// -----------------------------------------------------------------
`define CFG_DA_PRIO_BIT 0
`define CFG_RESET 1'h0

// -----------------------------------------------------------------
// Read-back high word fields
// -----------------------------------------------------------------
`define HI_VALID_BIT 26
`define HI_EOT_BIT 25
`define HI_STATIC_BIT 24
`define HI_FILTER_BIT 23
`define HI_PRIO_EN_BIT 22
`define HI_PRIO_MSB 21
`define HI_PRIO_LSB 19
`define HI_PORT_MSB 18
`define HI_PORT_LSB 16
`define HI_MAC_MSB 15
`define HI_RSVD_WIDTH 5

// -----------------------------------------------------------------
// Reset values and table size
// -----------------------------------------------------------------
`define READ_LOW_RESET 32'h00000000
`define MAC_HI_RESET 16'h0000
`define TABLE_DEPTH 512

// -----------------------------------------------------------------
// Bus responses
// -----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [hw/table_readback_pkg.sv]
// Types shared by the table read-back block
`default_nettype none
package table_readback_pkg;

  // One entry of the address lookup table
  typedef struct packed {
    logic valid;
    logic is_static;
    logic filter;
    logic prio_en;
    logic [2:0] prio;
    logic [2:0] port;
    logic [47:0] mac;
  } table_entry_t;

  // Decoded forwarding view of an entry
  typedef struct packed {
    logic [2:0] port_mask;
    logic port_reserved;
    logic prio_apply;
    logic [2:0] prio;
    logic drop_on_match;
    logic ageable;
  } entry_view_t;

  // Table walk states
  typedef enum logic [1:0] {
    WALK_IDLE,
    WALK_READ,
    WALK_CHECK
  } walk_state_t;

endpackage

`default_nettype wire

// [hw/entry_decode.sv]
// Decodes a found table entry into its forwarding view
`timescale 1ns/1ns
`default_nettype none

module entry_decode
  import table_readback_pkg::*;
(
  // Entry and global setting
  input wire table_entry_t entry,
  input wire logic da_prio_first,
  // Decoded view
  output var entry_view_t view
);

  // -----------------------------------------------------------------
  // Port field to port mask
  // -----------------------------------------------------------------
  function automatic logic [2:0] port_mask_of(input logic [2:0] code);
    case (code)
      3'h0: port_mask_of = 3'h1;
      3'h1: port_mask_of = 3'h2;
      3'h2: port_mask_of = 3'h4;
      3'h4: port_mask_of = 3'h3;
      3'h5: port_mask_of = 3'h5;
      3'h6: port_mask_of = 3'h6;
      3'h7: port_mask_of = 3'h7;
      default: port_mask_of = 3'h0;
    endcase
  endfunction

  assign view = '{
    port_mask: port_mask_of(entry.port),
    port_reserved: (entry.port == 3'h3),
    prio_apply: entry.prio_en & da_prio_first,
    prio: entry.prio,
    drop_on_match: entry.filter,
    ageable: ~entry.is_static
  };

endmodule

`default_nettype wire

// [hw/address_table_entry_readback.sv]
// Table walk and read-back register pair of the address lookup table, AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "table_readback_params.svh"

// Behaviour
// - Low word holds first 32 MAC bits
// - Only walk commands load read-back registers
// - Walk command write clears valid flag when no walk is running
// - Valid set on found entry, else stays
// - End flag set when table end reached
// - Bit 24 shows static; non-static entries age
// - Bit 23 shows filter, drop on match
// - Priority applied only when both enables set
// - Port field encodes single or multiple ports
// - High word bits 15:0 last MAC bits
module address_table_entry_readback
  import table_readback_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DEPTH = `TABLE_DEPTH,
  parameter int IDX_W = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // AXI4-Lite write address
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  // AXI4-Lite write data
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  // AXI4-Lite read data
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Lookup table read port, data one cycle after enable
  output logic TBL_RD_EN,
  output logic [IDX_W-1:0] TBL_RD_ADDR,
  input wire table_entry_t TBL_RD_DATA,
  // Forwarding view of the last found entry
  output var entry_view_t ENTRY_VIEW,
  output logic WALK_BUSY
);

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CMD,
    SEL_LOW,
    SEL_HIGH,
    SEL_CFG
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = 14'(addr[ADDR_W-1:2]);
    if (addr[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (idx == `IDX_TABLE_CMD) begin
      decode = SEL_CMD;
    end else if (idx == `IDX_READ_LOW) begin
      decode = SEL_LOW;
    end else if (idx == `IDX_READ_HIGH) begin
      decode = SEL_HIGH;
    end else if (idx == `IDX_INGRESS_CFG) begin
      decode = SEL_CFG;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // -----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // -----------------------------------------------------------------
  logic aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_rdy_r, w_rdy_r;

  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  wire reg_sel_t wr_sel = decode(aw_addr_r);
  wire wr_cmd = wr_fire & (wr_sel == SEL_CMD) & w_strb_r[0];
  wire wr_cfg = wr_fire & (wr_sel == SEL_CFG) & w_strb_r[0];
  wire wr_ok = (wr_sel != SEL_NONE);
  wire aw_held_nxt = aw_take | (aw_held_r & ~wr_fire);
  wire w_held_nxt = w_take | (w_held_r & ~wr_fire);
  wire bvalid_nxt = wr_fire | (bvalid_r & ~BREADY);

  assign AWREADY = aw_rdy_r;
  assign WREADY = w_rdy_r;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;

  // -----------------------------------------------------------------
  // Global ingress configuration
  // -----------------------------------------------------------------
  logic da_prio_first_r;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      da_prio_first_r <= `CFG_RESET;
    end else if (wr_cfg) begin
      da_prio_first_r <= w_data_r[`CFG_DA_PRIO_BIT];
    end
  end

  // -----------------------------------------------------------------
  // Table walk
  // -----------------------------------------------------------------
  walk_state_t state_r;
  walk_state_t state_nxt;
  logic [IDX_W-1:0] idx_r;
  logic [IDX_W-1:0] idx_nxt;
  logic [IDX_W-1:0] cursor_r;
  logic started_r;
  logic valid_r;
  logic eot_r;
  table_entry_t found_r;
  logic rd_en_r;

  wire cmd_first = wr_cmd & w_data_r[`CMD_GET_FIRST_BIT];
  wire cmd_next = wr_cmd & w_data_r[`CMD_GET_NEXT_BIT] & ~w_data_r[`CMD_GET_FIRST_BIT];
  wire cmd_go = (cmd_first | cmd_next) & (state_r == WALK_IDLE);
  wire next_at_end = cmd_next & started_r & (cursor_r == LAST_IDX);
  wire at_last = (idx_r == LAST_IDX);
  wire check = (state_r == WALK_CHECK);
  wire hit = check & TBL_RD_DATA.valid;
  wire miss_end = check & ~TBL_RD_DATA.valid & at_last;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      WALK_IDLE: begin
        if (cmd_go & ~next_at_end) begin
          state_nxt = WALK_READ;
          idx_nxt = (cmd_first | ~started_r) ? '0 : cursor_r + IDX_W'(1);
        end
      end
      WALK_READ: begin
        state_nxt = WALK_CHECK;
      end
      WALK_CHECK: begin
        if (hit | miss_end) begin
          state_nxt = WALK_IDLE;
        end else begin
          state_nxt = WALK_READ;
          idx_nxt = idx_r + IDX_W'(1);
        end
      end
      default: begin
        state_nxt = WALK_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r <= WALK_IDLE;
      idx_r <= '0;
      rd_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      rd_en_r <= (state_nxt == WALK_READ);
    end
  end

  assign TBL_RD_EN = rd_en_r;
  assign TBL_RD_ADDR = idx_r;

  // Cursor remembers the last checked index; once a walk has ended, a get-next walk resumes one past it, before that at index 0
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cursor_r <= '0;
      started_r <= 1'b0;
    end else if (hit | miss_end) begin
      cursor_r <= idx_r;
      started_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Read-back flags and entry
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      valid_r <= 1'b0;
      eot_r <= 1'b0;
    end else if (cmd_go) begin
      valid_r <= 1'b0;
      eot_r <= next_at_end;
    end else if (hit) begin
      valid_r <= 1'b1;
      eot_r <= at_last;
    end else if (miss_end) begin
      eot_r <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      found_r <= '0;
    end else if (hit) begin
      found_r <= TBL_RD_DATA;
    end
  end

  wire [31:0] read_low = found_r.mac[31:0];
  wire [31:0] read_high = {
    `HI_RSVD_WIDTH'(0),
    valid_r,
    eot_r,
    found_r.is_static,
    found_r.filter,
    found_r.prio_en,
    found_r.prio,
    found_r.port,
    found_r.mac[47:32]
  };

  // -----------------------------------------------------------------
  // Forwarding view of the found entry
  // -----------------------------------------------------------------
  entry_view_t view_comb;
  entry_view_t view_r;
  logic busy_r;

  entry_decode u_decode (
    .entry(found_r),
    .da_prio_first(da_prio_first_r),
    .view(view_comb)
  );

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      view_r <= '0;
      busy_r <= 1'b0;
    end else begin
      view_r <= view_comb;
      busy_r <= (state_nxt != WALK_IDLE);
    end
  end

  assign ENTRY_VIEW = view_r;
  assign WALK_BUSY = busy_r;

  // -----------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic ar_rdy_r;

  wire ar_take = ARVALID & ARREADY;
  wire reg_sel_t rd_sel = decode(ARADDR);

  // Ready flags track the next held and pending state
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      aw_rdy_r <= 1'b0;
      w_rdy_r <= 1'b0;
      ar_rdy_r <= 1'b0;
    end else begin
      aw_rdy_r <= ~aw_held_nxt & ~bvalid_nxt;
      w_rdy_r <= ~w_held_nxt & ~bvalid_nxt;
      ar_rdy_r <= ~ar_take & (~rvalid_r | RREADY);
    end
  end

  assign ARREADY = ar_rdy_r;

  always_comb begin
    case (rd_sel)
      SEL_CMD: rd_mux = {busy_r, 31'h00000000};
      SEL_LOW: rd_mux = read_low;
      SEL_HIGH: rd_mux = read_high;
      SEL_CFG: rd_mux = {31'h00000000, da_prio_first_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= `READ_LOW_RESET;
      rresp_r <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;

endmodule

`default_nettype wire

// [tb/table_readback_asserts.sv]
// Port checks for the table read-back block
`timescale 1ns/1ns
`default_nettype none

module table_readback_asserts #(
  parameter int IDX_W = 3
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic TBL_RD_EN,
  input wire logic [IDX_W-1:0] TBL_RD_ADDR,
  input wire logic WALK_BUSY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_step;
    TBL_RD_EN ##2 TBL_RD_EN;
  endsequence

  property p_rst;
    $fell(SYS_RST) |-> !BVALID && !RVALID && !WALK_BUSY && !TBL_RD_EN;
  endproperty
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
  endproperty
  property p_b_hold;
    BVALID && !BREADY |=> BVALID;
  endproperty
  property p_r_answer;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  property p_pace;
    TBL_RD_EN |=> !TBL_RD_EN && WALK_BUSY;
  endproperty
  property p_rd_busy;
    TBL_RD_EN |-> WALK_BUSY;
  endproperty
  property p_slverr;
    RVALID && RRESP == 2'h2 |-> RDATA == 32'h0;
  endproperty
  property p_step;
    s_step |-> TBL_RD_ADDR == $past(TBL_RD_ADDR, 2) + 1'b1;
  endproperty

  a_rst: assert property (p_rst)
    else $error("state not clear after reset");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  a_r_answer: assert property (p_r_answer)
    else $error("read not answered in next cycle");
  a_pace: assert property (p_pace)
    else $error("table read pace wrong");
  a_rd_busy: assert property (p_rd_busy)
    else $error("table read outside a walk");
  a_slverr: assert property (p_slverr)
    else $error("error read returned data");
  a_step: assert property (p_step)
    else $error("walk index did not step by one");
endmodule

bind address_table_entry_readback table_readback_asserts #(.IDX_W(IDX_W)) u_chk (
  .MCLK(MCLK),
  .SYS_RST(SYS_RST),
  .BVALID(BVALID),
  .BREADY(BREADY),
  .ARVALID(ARVALID),
  .ARREADY(ARREADY),
  .RVALID(RVALID),
  .RREADY(RREADY),
  .RDATA(RDATA),
  .RRESP(RRESP),
  .TBL_RD_EN(TBL_RD_EN),
  .TBL_RD_ADDR(TBL_RD_ADDR),
  .WALK_BUSY(WALK_BUSY)
);
`default_nettype wire

// [tb/address_table_entry_readback_tb.sv]
// Self-checking bench for the table read-back block
`timescale 1ns/1ns
`default_nettype none
`include "table_readback_params.svh"

module address_table_entry_readback_tb
  import table_readback_pkg::*;
;
  logic MCLK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TBL_RD_EN, WALK_BUSY;
  logic [15:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, r;
  logic [2:0] TBL_RD_ADDR;
  logic [2:0] pm [8];
  table_entry_t TBL_RD_DATA, e;
  table_entry_t tbl [8];
  entry_view_t ENTRY_VIEW, ev;
  logic cfg, v, eot;
  int n_mismatch, checked, p, k;
  localparam logic [15:0] adr_cmd = {`IDX_TABLE_CMD, 2'h0};
  localparam logic [15:0] adr_low = {`IDX_READ_LOW, 2'h0};
  localparam logic [15:0] adr_high = {`IDX_READ_HIGH, 2'h0};
  localparam logic [15:0] adr_cfg = {`IDX_INGRESS_CFG, 2'h0};
  localparam logic [15:0] adr_none = {`IDX_INGRESS_CFG + 14'h1, 2'h0};

  address_table_entry_readback #(.DEPTH(8)) uut (
    .MCLK(MCLK), .SYS_RST(SYS_RST),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .TBL_RD_EN(TBL_RD_EN), .TBL_RD_ADDR(TBL_RD_ADDR), .TBL_RD_DATA(TBL_RD_DATA),
    .ENTRY_VIEW(ENTRY_VIEW), .WALK_BUSY(WALK_BUSY)
  );

  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // Table memory, garbage when not read
  always @(posedge MCLK) begin
    if (SYS_RST) TBL_RD_DATA <= '0;
    else if (TBL_RD_EN) TBL_RD_DATA <= tbl[TBL_RD_ADDR];
    else TBL_RD_DATA <= ~TBL_RD_DATA;
  end

  // ------------------------------
  // Bus and check tasks
  // ------------------------------
  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n > 200) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge MCLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= dt;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
      tmo(n);
    end while (!BVALID);
    BREADY <= 1'b0;
    r = BRESP;
  endtask

  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge MCLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
      tmo(n);
    end while (!RVALID);
    RREADY <= 1'b0;
    d = RDATA;
    r = RRESP;
  endtask

  task automatic readback();
    logic [31:0] x;
    x = {5'h0, v, eot, e.is_static, e.filter, e.prio_en, e.prio, e.port, e.mac[47:32]};
    rd(adr_high);
    chk("read_high", d, x);
    rd(adr_low);
    chk("read_low", d, e.mac[31:0]);
    ev = '{pm[e.port], e.port == 3'h3, e.prio_en & cfg, e.prio, e.filter, ~e.is_static};
    if (v) chk("view", {22'h0, ENTRY_VIEW}, {22'h0, ev});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
      tmo(n);
    end while (WALK_BUSY);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    SYS_RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hF;
    pm = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
    {e, v, eot, cfg} = '0;
    {n_mismatch, checked, p} = '0;
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    readback();
    wr(adr_low, 32'hFFFFFFFF);
    chk("bresp_low", {30'h0, r}, {30'h0, `RESP_OKAY});
    wr(adr_high, 32'hFFFFFFFF);
    chk("bresp_high", {30'h0, r}, {30'h0, `RESP_OKAY});
    readback();
    rd(adr_none);
    chk("rresp_unmapped", {30'h0, r}, {30'h0, `RESP_SLVERR});
    chk("rdata_unmapped", d, 32'h0);
    for (int pass = 0; pass < 2; pass++) begin
      cfg = (pass == 0);
      for (int i = 0; i < 8; i++) begin
        tbl[i] = {1'(i % 2 == pass), i[1], i[2], 1'b1, i[2:0], i[2:0],
                  {6{8'(i)}} ^ 48'hA1B2C3D4E5F6};
      end
      wr(adr_cfg, {31'h0, cfg});
      rd(adr_cfg);
      chk("cfg", d, {31'h0, cfg});
      for (int c = 0; c < 5; c++) begin
        // First walk of the first pass opens with get-next alone, of the second pass with both bits
        wr(adr_cmd, (c > 0) ? 32'h2 : (pass == 0) ? 32'h2 : 32'h3);
        wait_idle();
        k = (c == 0) ? 0 : p + 1;
        while (k < 8 && !tbl[k].valid) k++;
        v = (k < 8);
        eot = (k >= 7);
        if (v) e = tbl[k];
        p = v ? k : 7;
        readback();
      end
    end
    results();
  end
endmodule
`default_nettype wire
